// File: hw/timer8_compare_waveform_output.sv
/*
  Top of the 8-bit compare timer: AHB-Lite register slave, flags,
  prescale divider, counter core and pin override.
  Assumes a single AHB-Lite master, word transfers, one clock hclk.
*/
module timer8_compare_waveform_output
  import tmr8_pkg::*;
#(
  parameter int unsigned PRESCALE_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // compare pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // flag lines toward an interrupt controller
  input wire logic overflow_serviced,
  input wire logic match_serviced,
  output logic overflow_flag,
  output logic compare_match_flag
);
  typedef struct packed {
    logic       ph_valid;
    logic       ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic [1:0] compare_output_action;
    logic [1:0] waveform_mode_select;
    logic [7:0] compare_value;
    logic       port_value;
    logic       compare_pin_direction_bit;
    logic [PRESCALE_W-1:0] prescale;
    logic       run;
    logic       load_count;
    logic [7:0] load_value;
    logic       force_compare_strobe;
    logic       overflow_flag;
    logic       compare_match_flag;
    logic       pin_out;
    logic       pin_oe;
    logic       pin_s1;
    logic       pin_s2;
  } state_t;

  state_t st;
  state_t next_st;
  timer_ctl_t ctl;
  timer_sts_t sts;
  logic tick;

  function automatic logic [31:0] read_mux(input state_t s, input timer_sts_t t);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (s.ph_addr)
      OFS_CONTROL:
      begin
        r[CTL_COM_LSB +: 2] = s.compare_output_action;
        r[CTL_WGM_LSB +: 2] = s.waveform_mode_select;
      end
      OFS_COUNT: r[7:0] = t.count_value;
      OFS_COMPARE: r[7:0] = s.compare_value;
      OFS_FLAGS:
      begin
        r[FLG_OVF_BIT] = s.overflow_flag;
        r[FLG_CMP_BIT] = s.compare_match_flag;
      end
      OFS_PORT:
      begin
        r[PRT_OUT_BIT] = s.port_value;
        r[PRT_DIR_BIT] = s.compare_pin_direction_bit;
        r[PRT_PIN_BIT] = s.pin_s2;
      end
      OFS_PRESCALE:
      begin
        r[PRESCALE_W-1:0] = s.prescale;
        r[31] = s.run;
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  tick_divider #(
    .DIV_W(PRESCALE_W)
  ) u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(st.run),
    .div(st.prescale),
    .tick(tick)
  );

  always_comb
  begin
    ctl.waveform_mode_select = st.waveform_mode_select;
    ctl.compare_output_action = st.compare_output_action;
    ctl.compare_value = st.compare_value;
    ctl.load_count = st.load_count;
    ctl.load_value = st.load_value;
    ctl.force_compare_strobe = st.force_compare_strobe;
  end

  timer_core u_core (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .ctl(ctl),
    .sts(sts)
  );

  always_comb
  begin
    next_st = st;
    next_st.load_count = 1'b0;
    next_st.force_compare_strobe = 1'b0;
    next_st.pin_s1 = pin_in;
    next_st.pin_s2 = st.pin_s1;
    // data phase: zero wait states
    if (st.ph_valid && st.ph_write)
    begin
      unique case (st.ph_addr)
        OFS_CONTROL:
        begin
          next_st.compare_output_action = hwdata[CTL_COM_LSB +: 2];
          next_st.waveform_mode_select = hwdata[CTL_WGM_LSB +: 2];
          next_st.force_compare_strobe = hwdata[CTL_FORCE_BIT];
        end
        OFS_COUNT:
        begin
          next_st.load_count = 1'b1;
          next_st.load_value = hwdata[7:0];
        end
        OFS_COMPARE: next_st.compare_value = hwdata[7:0];
        OFS_PORT:
        begin
          next_st.port_value = hwdata[PRT_OUT_BIT];
          next_st.compare_pin_direction_bit = hwdata[PRT_DIR_BIT];
        end
        OFS_PRESCALE:
        begin
          next_st.prescale = hwdata[PRESCALE_W-1:0];
          next_st.run = hwdata[31];
        end
        default:
        begin
        end
      endcase
    end
    // flags: clear by servicing or write-one; a new event wins
    if (overflow_serviced || (st.ph_valid && st.ph_write && st.ph_addr == OFS_FLAGS
        && hwdata[FLG_OVF_BIT]))
      next_st.overflow_flag = 1'b0;
    if (match_serviced || (st.ph_valid && st.ph_write && st.ph_addr == OFS_FLAGS
        && hwdata[FLG_CMP_BIT]))
      next_st.compare_match_flag = 1'b0;
    if (sts.overflow_event)
      next_st.overflow_flag = 1'b1;
    if (sts.match_event)
      next_st.compare_match_flag = 1'b1;
    // address phase
    next_st.ph_valid = 1'b0;
    if (hsel && hready && htrans == HTRANS_NONSEQ)
    begin
      next_st.ph_valid = 1'b1;
      next_st.ph_write = hwrite;
      next_st.ph_addr = haddr[7:0];
    end
    next_st.rdata = 32'h0000_0000;
    if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite)
    begin
      next_st.ph_addr = haddr[7:0];
      next_st.rdata = read_mux(next_st, sts);
    end
    // state is kept even when the pin is an input
    next_st.pin_out = (st.compare_output_action != COM_NONE)
      ? sts.compare_output_state : st.port_value;
    next_st.pin_oe = st.compare_pin_direction_bit;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st <= '0;
      st.prescale <= PRESCALE_RESET;
    end
    else
      st <= next_st;
  end

  assign hrdata = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pin_out = st.pin_out;
  assign pin_oe = st.pin_oe;
  assign overflow_flag = st.overflow_flag;
  assign compare_match_flag = st.compare_match_flag;
endmodule

// File: include/tmr8_pkg.sv
/*
  Shared constants and carrier types for the 8-bit compare timer.
  Assumes a single 250 MHz bus clock and an AHB-Lite register port.
*/
package tmr8_pkg;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  // waveform_mode_select encodings
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PHASE = 2'h1;
  localparam logic [1:0] WGM_CLEAR_ON_MATCH = 2'h2;
  localparam logic [1:0] WGM_FAST_PWM = 2'h3;

  // compare_output_action encodings
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_PORT = 8'h10;
  localparam logic [7:0] OFS_PRESCALE = 8'h14;

  // control register fields
  localparam int unsigned CTL_COM_LSB = 0;
  localparam int unsigned CTL_WGM_LSB = 2;
  localparam int unsigned CTL_FORCE_BIT = 4;
  // flag register fields (write one to clear)
  localparam int unsigned FLG_OVF_BIT = 0;
  localparam int unsigned FLG_CMP_BIT = 1;
  // port register fields
  localparam int unsigned PRT_OUT_BIT = 0;
  localparam int unsigned PRT_DIR_BIT = 1;
  localparam int unsigned PRT_PIN_BIT = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [15:0] PRESCALE_RESET = 16'h0000;

  typedef struct packed {
    logic [1:0] waveform_mode_select;
    logic [1:0] compare_output_action;
    logic [7:0] compare_value;
    logic       load_count;
    logic [7:0] load_value;
    logic       force_compare_strobe;
  } timer_ctl_t;

  typedef struct packed {
    logic [7:0] count_value;
    logic [7:0] compare_active;
    logic       overflow_event;
    logic       match_event;
    logic       compare_output_state;
  } timer_sts_t;

  typedef struct packed {
    logic pin_out;
    logic pin_oe;
  } pin_drive_t;
endpackage

// File: hw/tick_divider.sv
/*
  Timer clock enable generator: one-cycle pulse every (div+1) clocks.
  Assumes the divisor comes from a register on the same clock.
*/
module tick_divider #(
  parameter int unsigned DIV_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic run,
  input wire logic [DIV_W-1:0] div,
  // enable out
  output logic tick
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } state_t;

  state_t st;
  state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run)
    begin
      next_st.cnt = '0;
    end
    else if (st.cnt >= div)
    begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;
endmodule

// File: hw/timer_core.sv
/*
  Counter, comparator and waveform generator of the 8-bit timer.
  Assumes tick is a one-cycle enable and control comes from the same clock.
*/
module timer_core
  import tmr8_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // timer enable
  input wire logic tick,
  // control
  input wire tmr8_pkg::timer_ctl_t ctl,
  // status
  output tmr8_pkg::timer_sts_t sts
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] ocr;
    logic       block;
    logic       ovf;
    logic       mat;
    logic       oc;
    logic       cmp_hit;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic wave_action(input logic [1:0] com, input logic cur);
    unique case (com)
      COM_NONE: wave_action = cur;
      COM_TOGGLE: wave_action = ~cur;
      COM_CLEAR: wave_action = 1'b0;
      COM_SET: wave_action = 1'b1;
    endcase
  endfunction

  logic is_pwm;
  logic hit;

  always_comb
  begin
    next_st = st;
    next_st.ovf = 1'b0;
    next_st.mat = 1'b0;
    is_pwm = (ctl.waveform_mode_select == WGM_FAST_PWM);
    // unbuffered outside fast pwm; pwm reloads only at max->bottom
    if (!is_pwm)
      next_st.ocr = ctl.compare_value;
    hit = (st.cnt == st.ocr) && !st.block;
    if (ctl.load_count)
    begin
      next_st.cnt = ctl.load_value;
      next_st.block = 1'b1;
    end
    else if (tick)
    begin
      next_st.block = 1'b0;
      if (hit)
      begin
        next_st.mat = 1'b1;
        next_st.oc = wave_action(ctl.compare_output_action, st.oc);
        if (is_pwm && ctl.compare_output_action != COM_TOGGLE)
          next_st.oc = (ctl.compare_output_action == COM_SET);
      end
      unique case (ctl.waveform_mode_select)
        WGM_CLEAR_ON_MATCH:
        begin
          if (hit)
            next_st.cnt = CNT_BOTTOM;
          else
            next_st.cnt = st.cnt + 8'h01;
          if (st.cnt == CNT_MAX && !hit)
            next_st.ovf = 1'b1;
        end
        WGM_FAST_PWM:
        begin
          next_st.cnt = st.cnt + 8'h01;
          if (st.cnt == CNT_MAX)
          begin
            next_st.ovf = 1'b1;
            next_st.ocr = ctl.compare_value;
            // bottom action; a match at max wins so ocr=max holds a level
            if (!hit && ctl.compare_output_action[1])
              next_st.oc = (ctl.compare_output_action == COM_CLEAR);
          end
        end
        default:
        begin
          // normal; the phase-correct code is left as free running
          next_st.cnt = st.cnt + 8'h01;
          if (st.cnt == CNT_MAX)
            next_st.ovf = 1'b1;
        end
      endcase
    end
    // strobe acts like a match on the state only, normal and clear-on-match modes
    if (ctl.force_compare_strobe && !is_pwm && ctl.waveform_mode_select != WGM_PHASE)
      next_st.oc = wave_action(ctl.compare_output_action, st.oc);
    next_st.cmp_hit = hit;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else
      st <= next_st;
  end

  always_comb
  begin
    sts.count_value = st.cnt;
    sts.compare_active = st.ocr;
    sts.overflow_event = st.ovf;
    sts.match_event = st.mat;
    sts.compare_output_state = st.oc;
  end
endmodule

// File: verif/pin_load.sv
/*
  External load on the compare pin: a weak pull-up that the timer
  overrides while it drives. Assumes one driver, the timer itself.
*/
module pin_load #(
  parameter bit PULL_LEVEL = 1'b1
) (
  // timer side
  input wire logic pin_out,
  input wire logic pin_oe,
  // resolved level
  output logic pin_level
);
  // released pin floats to the pull level, never to the last value
  assign pin_level = pin_oe ? pin_out : PULL_LEVEL;
endmodule

// File: verif/tmr8_asserts.sv
/*
  Checker for the compare timer top: pin override, flag clearing, bus reply.
  Assumes hready is tied to hreadyout and only word transfers are made.
*/
module tmr8_asserts
  import tmr8_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // pin and flags
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic overflow_serviced,
  input wire logic match_serviced,
  input wire logic overflow_flag,
  input wire logic compare_match_flag
);
  logic wr_dph, run, flg_wr;
  logic [7:0] wr_ofs;
  logic [1:0] act, prt;
  logic [2:0] quiet;
  assign flg_wr = wr_dph && wr_ofs == OFS_FLAGS;
  // quiet covers the register-to-pin pipeline after any write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_dph <= 1'b0;
      wr_ofs <= 8'h00;
      act <= COM_NONE;
      prt <= 2'h0;
      run <= 1'b0;
      quiet <= 3'h7;
    end
    else
    begin
      wr_dph <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
      wr_ofs <= haddr[7:0];
      if (wr_dph && wr_ofs == OFS_CONTROL)
        act <= hwdata[1:0];
      if (wr_dph && wr_ofs == OFS_PORT)
        prt <= hwdata[1:0];
      if (wr_dph && wr_ofs == OFS_PRESCALE)
        run <= hwdata[31];
      quiet <= wr_dph ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_pass_thru;
    quiet == 3'h7 && act == COM_NONE |-> pin_out == prt[PRT_OUT_BIT];
  endproperty
  a_pass_thru: assert property (p_pass_thru) else $error("pin not port value");
  property p_dir;
    quiet == 3'h7 |-> pin_oe == prt[PRT_DIR_BIT];
  endproperty
  a_dir: assert property (p_dir) else $error("pin enable not direction bit");
  property p_ovf_clr;
    $fell(overflow_flag) |-> $past(overflow_serviced) || $past(overflow_serviced, 2)
      || $past(flg_wr && hwdata[FLG_OVF_BIT]) || $past(flg_wr && hwdata[FLG_OVF_BIT], 2);
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow dropped by itself");
  property p_cmp_clr;
    $fell(compare_match_flag) |-> $past(match_serviced) || $past(match_serviced, 2)
      || $past(flg_wr && hwdata[FLG_CMP_BIT]) || $past(flg_wr && hwdata[FLG_CMP_BIT], 2);
  endproperty
  a_cmp_clr: assert property (p_cmp_clr) else $error("match flag dropped by itself");
  property p_stop_ovf;
    quiet == 3'h7 && !run |-> !$rose(overflow_flag);
  endproperty
  a_stop_ovf: assert property (p_stop_ovf) else $error("overflow while stopped");
  property p_stop_cmp;
    quiet == 3'h7 && !run |-> !$rose(compare_match_flag);
  endproperty
  a_stop_cmp: assert property (p_stop_cmp) else $error("match flag while stopped");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_ready;
    hreadyout == 1'b1;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
endmodule
bind timer8_compare_waveform_output tmr8_asserts tmr8_asserts_inst (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .pin_out, .pin_oe,
  .overflow_serviced, .match_serviced, .overflow_flag, .compare_match_flag);

// File: verif/timer8_compare_waveform_output_tb.sv
/*
  Self-checking bench: registers, normal, clear-on-match, fast pwm, force.
  Assumes the pin load model and the bound checker.
*/
module timer8_compare_waveform_output_tb;
  import tmr8_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hwrite, hreadyout, hresp, pin_in, pin_out, pin_oe;
  logic overflow_serviced, match_serviced, overflow_flag, compare_match_flag;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  int n_errors, checks, cyc, hi, per;
  timer8_compare_waveform_output #(.PRESCALE_W(16)) timer8_compare_waveform_output_inst (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe,
    .overflow_serviced, .match_serviced, .overflow_flag, .compare_match_flag);
  pin_load pin_load_inst (.pin_out, .pin_oe, .pin_level(pin_in));
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rdata, e);
  endtask
  // bounded only by the global cycle ceiling
  task automatic wait_ovf(output int n);
    n = 0;
    while (overflow_flag !== 1'b1)
    begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic pw(output int h, output int p);
    while (pin_out !== 1'b0) @(posedge hclk);
    while (pin_out !== 1'b1) @(posedge hclk);
    h = 0;
    while (pin_out === 1'b1)
    begin
      @(posedge hclk);
      h++;
    end
    p = h;
    while (pin_out === 1'b0)
    begin
      @(posedge hclk);
      p++;
    end
  endtask
  task automatic t_regs();
    rdchk(OFS_CONTROL, 32'h0000_0000);
    rdchk(OFS_FLAGS, 32'h0000_0000);
    rdchk(OFS_PRESCALE, {16'h0000, PRESCALE_RESET});
    wr(OFS_COMPARE, 32'h0000_005A);
    rdchk(OFS_COMPARE, 32'h0000_005A);
    wr(8'h40, 32'hFFFF_FFFF);
    rdchk(8'h40, 32'h0000_0000);
    rdchk(OFS_PORT, 32'h0000_0004);
    $display("regs done");
  endtask
  task automatic t_normal();
    int n;
    wr(OFS_COUNT, 32'h0000_00F0);
    // count load reaches the core one clock after the write lands
    @(posedge hclk);
    rdchk(OFS_COUNT, 32'h0000_00F0);
    wr(OFS_COMPARE, 32'h0000_00F8);
    wr(OFS_PRESCALE, 32'h8000_0000);
    wait_ovf(n);
    chk(n >= 16 && n <= 22, 1'b1);
    chk(compare_match_flag, 1'b1);
    wr(OFS_PRESCALE, 32'h0000_0000);
    wr(OFS_FLAGS, 32'h0000_0001);
    rdchk(OFS_FLAGS, 32'h0000_0002);
    match_serviced <= 1'b1;
    @(posedge hclk);
    match_serviced <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(compare_match_flag, 1'b0);
    $display("normal done");
  endtask
  task automatic t_force();
    logic [31:0] cnt;
    wr(OFS_PORT, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0003);
    xfer(1'b0, OFS_COUNT, 32'h0000_0000);
    cnt = rdata;
    wr(OFS_CONTROL, 32'h0000_0013);
    repeat (4) @(posedge hclk);
    chk(pin_out, 1'b1);
    chk(pin_oe, 1'b0);
    chk(compare_match_flag, 1'b0);
    rdchk(OFS_COUNT, cnt);
    rdchk(OFS_CONTROL, 32'h0000_0003);
    wr(OFS_PORT, 32'h0000_0002);
    repeat (4) @(posedge hclk);
    rdchk(OFS_PORT, 32'h0000_0006);
    wr(OFS_CONTROL, 32'h0000_0000);
    repeat (4) @(posedge hclk);
    chk(pin_out, 1'b0);
    $display("force done");
  endtask
  task automatic t_ctc();
    int n;
    wr(OFS_COUNT, 32'h0000_0010);
    wr(OFS_COMPARE, 32'h0000_0008);
    wr(OFS_CONTROL, 32'h0000_0009);
    wr(OFS_PRESCALE, 32'h8000_0000);
    wait_ovf(n);
    chk(compare_match_flag, 1'b0);
    wr(OFS_COMPARE, 32'h0000_0003);
    wr(OFS_PRESCALE, 32'h8000_0001);
    pw(hi, per);
    pw(hi, per);
    chk(hi, 8);
    chk(per, 16);
    $display("clear on match done");
  endtask
  task automatic t_pwm();
    wr(OFS_PRESCALE, 32'h0000_0000);
    wr(OFS_COUNT, 32'h0000_0000);
    wr(OFS_COMPARE, 32'h0000_0040);
    wr(OFS_CONTROL, 32'h0000_000E);
    wr(OFS_PRESCALE, 32'h8000_0000);
    pw(hi, per);
    chk(hi, 65);
    chk(per, 256);
    while (pin_out !== 1'b0) @(posedge hclk);
    while (pin_out !== 1'b1) @(posedge hclk);
    hi = 0;
    // compare rewritten mid-pulse must not cut the current period
    fork
      wr(OFS_COMPARE, 32'h0000_0000);
      while (pin_out === 1'b1)
      begin
        @(posedge hclk);
        hi++;
      end
    join
    chk(hi, 65);
    pw(hi, per);
    chk(hi, 1);
    chk(overflow_flag, 1'b1);
    wr(OFS_CONTROL, 32'h0000_000F);
    pw(hi, per);
    pw(hi, per);
    chk(hi, 255);
    // toggle at compare zero: one match per 256-tick period
    wr(OFS_CONTROL, 32'h0000_000D);
    pw(hi, per);
    pw(hi, per);
    chk(hi, 256);
    chk(per, 512);
    wr(OFS_PRESCALE, 32'h0000_0000);
    overflow_serviced <= 1'b1;
    @(posedge hclk);
    overflow_serviced <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(overflow_flag, 1'b0);
    $display("fast pwm done");
  endtask
  initial
  begin
    hresetn = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    overflow_serviced = 1'b0;
    match_serviced = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_normal();
    t_force();
    t_ctc();
    t_pwm();
    complete_run();
  end
endmodule
